/* verilog/eis_map.svh */
// Constants for the equipment identifier store command handler.
`ifndef EIS_MAP_SVH
`define EIS_MAP_SVH
`define EIS_CLA 8'hA0
`define EIS_INS 8'hDE
`define EIS_P1_SERIAL 8'h00
`define EIS_P1_LONG 8'h01
`define EIS_P2 8'h00
`define EIS_LC 8'h08
`define EIS_LE 8'h01
`define EIS_ID_BYTES 7
`define EIS_LEN_MAX 4'h7
`define EIS_FILE_ID 16'h6F38
`define EIS_USG_FILE_ID 16'h6F42
`define EIS_SW_OK 16'h9000
`define EIS_SW_BAD_P1P2 16'h6B00
`define EIS_SW_BAD_LEN 16'h6700
`define EIS_SW_BAD_INS 16'h6D00
`define EIS_SW_BAD_CLA 16'h6E00
`define EIS_CHG_BIT 0
`define EIS_USG_BIT 4
`define EIS_SEC_BIT 5
`endif

/* verilog/eis_pkg.sv */
// Types for the equipment identifier store command handler.
package eis_pkg;
  typedef enum logic [2:0] {
    EIS_IDLE,
    EIS_HDR,
    EIS_DATA,
    EIS_CHECK,
    EIS_REPLY
  } eis_state_e;
  typedef logic [55:0] eis_id_t;
endpackage : eis_pkg

/* verilog/eis_id_file.sv */
// Equipment identity file storage with change detection.
`timescale 1ns/1ns
`include "eis_map.svh"
module eis_id_file
  import eis_pkg::*;
#(
  parameter int Bytes = `EIS_ID_BYTES
) (
  input wire logic clk, // Clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic writeEn, // One-cycle write strobe.
  input wire logic [8*Bytes-1:0] writeData, // New identifier.
  output logic [8*Bytes-1:0] fileData, // Stored identifier.
  output logic changed // New value differs from stored.
);
  logic [7:0] mem_q [Bytes];
  always_comb begin
    changed = 1'b0;
    for (int i = 0; i < Bytes; i++) begin
      fileData[8*i +: 8] = mem_q[i];
      if (mem_q[i] != writeData[8*i +: 8]) begin
        changed = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < Bytes; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (writeEn) begin
      for (int i = 0; i < Bytes; i++) begin
        mem_q[i] <= writeData[8*i +: 8];
      end
    end
  end
endmodule : eis_id_file

/* verilog/eis_store_cmd.sv */
// Card-side handler for the equipment identifier store command.
`timescale 1ns/1ns
`include "eis_map.svh"
// How it works
// - Accept class A0, instruction DE, P2 zero, eight data bytes, one reply.
// - Selector 00: octet 1 low nibble is length, octets 2-8 serial.
// - Identifier bytes arrive least significant first, stored as received.
// - Selector 00 writes the serial number into file 6F38.
// - Reply bit 0 set when new identifier differs from the stored one.
// - Reply bits 1 to 3 are zero.
// - Selector 00 reply bit 4 reports the usage indicator of file 6F42.
// - Selector 00 reply bits 5 to 7 are zero.
// - Selector 01: low nibble length, seven-byte long identifier into 6F38.
// - Selector 01 reply bit 4 reports the usage indicator as well.
// - Selector 01 reply bit 5 reports secure identifier replacement.
// - Selector 01 reply bits 6 and 7 are zero.
// - Under T=0 the command unit maps onto a transport unit.
module eis_store_cmd
  import eis_pkg::*;
(
  input wire logic clk, // Clock, 10 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic cmdValid, // Command byte strobe.
  input wire logic [7:0] cmdByte, // Command byte stream.
  input wire logic usageIndicator, // Usage indicator from file 6F42.
  input wire logic secureIdUsed, // Card secure equipment id in use.
  output logic respValid, // Reply strobe, one cycle.
  output logic [7:0] respByte, // Reply octet.
  output logic [15:0] statusWord, // Status word with the reply.
  output logic fileWrite, // Pulse when file 6F38 is written.
  output logic [55:0] fileData, // Contents of file 6F38.
  output logic busy // Command in progress.
);
  // -------------------------------------------------------------------
  // Header and data capture
  // -------------------------------------------------------------------
  eis_state_e state_q;
  logic [2:0] hdrCnt_q;
  logic [3:0] dataCnt_q;
  logic [7:0] cla_q;
  logic [7:0] ins_q;
  logic [7:0] p1_q;
  logic [7:0] p2_q;
  logic [7:0] lc_q;
  logic [7:0] le_q;
  logic [3:0] idLen_q;
  eis_id_t idBuf_q;
  logic writeEn;
  logic changed;
  logic [55:0] fileOut;
  logic [7:0] reply;
  logic [15:0] sw;
  // -------------------------------------------------------------------
  // Command sequencing
  // -------------------------------------------------------------------
  // The sequencer counts six header bytes and then eight data bytes.
  // A header whose Lc is not eight skips the data phase entirely.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= EIS_IDLE;
      hdrCnt_q <= 3'h0;
      dataCnt_q <= 4'h0;
    end else begin
      case (state_q)
        EIS_IDLE: begin
          if (cmdValid) begin
            state_q <= EIS_HDR;
            hdrCnt_q <= 3'h1;
          end
        end
        EIS_HDR: begin
          if (cmdValid) begin
            hdrCnt_q <= hdrCnt_q + 3'h1;
            if (hdrCnt_q == 3'h5) begin
              dataCnt_q <= 4'h0;
              // Transport unit under T=0 carries Lc data bytes next.
              state_q <= (lc_q == `EIS_LC) ? EIS_DATA : EIS_CHECK;
            end
          end
        end
        EIS_DATA: begin
          if (cmdValid) begin
            dataCnt_q <= dataCnt_q + 4'h1;
            if (dataCnt_q == 4'h7) begin
              state_q <= EIS_CHECK;
            end
          end
        end
        EIS_CHECK: begin
          // Bytes offered here are dropped while the reply is formed.
          state_q <= EIS_REPLY;
        end
        EIS_REPLY: begin
          state_q <= EIS_IDLE;
        end
        default: state_q <= EIS_IDLE;
      endcase
    end
  end
  // Each header byte is kept so that the check sees the whole header.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cla_q <= 8'h00;
      ins_q <= 8'h00;
      p1_q <= 8'h00;
      p2_q <= 8'h00;
      lc_q <= 8'h00;
      le_q <= 8'h00;
    end else if (cmdValid) begin
      if (state_q == EIS_IDLE) begin
        cla_q <= cmdByte;
      end else if (state_q == EIS_HDR) begin
        case (hdrCnt_q)
          3'h1: ins_q <= cmdByte;
          3'h2: p1_q <= cmdByte;
          3'h3: p2_q <= cmdByte;
          3'h4: lc_q <= cmdByte;
          3'h5: le_q <= cmdByte;
          default: le_q <= le_q;
        endcase
      end
    end
  end
  // -------------------------------------------------------------------
  // Identifier capture
  // -------------------------------------------------------------------
  // The buffer is only copied to the file once the command checks out.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idLen_q <= 4'h0;
      idBuf_q <= 56'h0000_0000_0000_00;
    end else if (cmdValid && state_q == EIS_DATA) begin
      if (dataCnt_q == 4'h0) begin
        idLen_q <= cmdByte[3:0]; // Bits 4-7 reserved, ignored.
      end else begin
        // Byte k lands at bits 8(k-1): least significant first.
        idBuf_q[8*(dataCnt_q-4'h1) +: 8] <= cmdByte;
      end
    end
  end
  // -------------------------------------------------------------------
  // Checking and reply
  // -------------------------------------------------------------------
  // Errors are reported in a fixed order of priority.
  // The first failing field decides the status word.
  function automatic logic [15:0] checkStatus(
      input logic [7:0] c,
      input logic [7:0] i,
      input logic [7:0] p1,
      input logic [7:0] p2,
      input logic [7:0] lc,
      input logic [7:0] le,
      input logic [3:0] len);
    if (c != `EIS_CLA) begin
      return `EIS_SW_BAD_CLA;
    end else if (i != `EIS_INS) begin
      return `EIS_SW_BAD_INS;
    end else if ((p1 != `EIS_P1_SERIAL && p1 != `EIS_P1_LONG) ||
        p2 != `EIS_P2) begin
      return `EIS_SW_BAD_P1P2;
    end else if (lc != `EIS_LC || le != `EIS_LE || len > `EIS_LEN_MAX) begin
      return `EIS_SW_BAD_LEN;
    end
    return `EIS_SW_OK;
  endfunction : checkStatus
  always_comb begin
    sw = checkStatus(cla_q, ins_q, p1_q, p2_q, lc_q, le_q, idLen_q);
    writeEn = (state_q == EIS_CHECK) && (sw == `EIS_SW_OK);
    // Bits 1 to 3 and the reserved high bits stay zero.
    reply = 8'h00;
    reply[`EIS_CHG_BIT] = changed;
    reply[`EIS_USG_BIT] = usageIndicator;
    // The secure identifier bit only has meaning for the long identifier.
    if (p1_q == `EIS_P1_LONG) begin
      reply[`EIS_SEC_BIT] = secureIdUsed;
    end
  end
  // -------------------------------------------------------------------
  // File storage
  // -------------------------------------------------------------------
  // The file compares its old contents with the buffer for the flag.
  eis_id_file #(
    .Bytes(`EIS_ID_BYTES)
  ) u_file (
    .clk(clk),
    .resetn(resetn),
    .writeEn(writeEn),
    .writeData(idBuf_q),
    .fileData(fileOut),
    .changed(changed)
  );
  // -------------------------------------------------------------------
  // Registered outputs
  // -------------------------------------------------------------------
  // Every output is registered so the terminal side sees clean levels.
  // Reply and status hold until the next command completes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      respValid <= 1'b0;
      respByte <= 8'h00;
      statusWord <= 16'h0000;
      fileWrite <= 1'b0;
      fileData <= 56'h0000_0000_0000_00;
      busy <= 1'b0;
    end else begin
      respValid <= (state_q == EIS_CHECK);
      fileWrite <= writeEn;
      fileData <= writeEn ? idBuf_q : fileOut;
      // Busy rises with the first header byte, not one cycle later.
      busy <= (state_q != EIS_IDLE) || cmdValid;
      if (state_q == EIS_CHECK) begin
        statusWord <= sw;
        respByte <= (sw == `EIS_SW_OK) ? reply : 8'h00;
      end
    end
  end
endmodule : eis_store_cmd

/* sim/eis_store_cmd_sva.sv */
// Assertions for the identifier store command handler.
`timescale 1ns/1ns
module eis_store_cmd_sva (
  input wire logic clk, // Clock.
  input wire logic resetn, // Reset.
  input wire logic usageIndicator, // Usage.
  input wire logic respValid, // Reply strobe.
  input wire logic [7:0] respByte, // Reply.
  input wire logic [15:0] statusWord, // Status.
  input wire logic fileWrite, // Write pulse.
  input wire logic [55:0] fileData, // File.
  input wire logic busy // Busy.
);
  localparam logic [15:0] Ok = 16'h9000;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence replyEnd;
    busy ##1 busy;
  endsequence
  pulse_end_a: assert property (respValid |-> replyEnd)
    else $error("reply framing");
  write_ok_a: assert property (fileWrite |-> statusWord == Ok)
    else $error("bad write");
  ok_write_a: assert property (respValid && statusWord == Ok |-> fileWrite)
    else $error("no write");
  rfu_zero_a: assert property (
    respValid |-> respByte[3:1] == 3'h0 && respByte[7:6] == 2'h0)
    else $error("reserved bits");
  usage_bit_a: assert property (
    fileWrite |-> respByte[4] == $past(usageIndicator))
    else $error("usage bit");
  change_bit_a: assert property (fileWrite |->
    respByte[0] == (fileData != $past(fileData))) else $error("change bit");
  err_quiet_a: assert property (respValid && statusWord != Ok |-> respByte == 8'h00)
    else $error("error reply");
  file_hold_a: assert property ($changed(fileData) |-> fileWrite)
    else $error("file changed");
endmodule : eis_store_cmd_sva
bind eis_store_cmd eis_store_cmd_sva sva (.clk(clk), .resetn(resetn),
  .usageIndicator(usageIndicator), .respValid(respValid),
  .respByte(respByte), .statusWord(statusWord), .fileWrite(fileWrite),
  .fileData(fileData), .busy(busy));

/* sim/eis_terminal_model.sv */
// Terminal model that sends one command frame a byte at a time.
`timescale 1ns/1ns
module eis_terminal_model (
  input wire logic clk, // Clock.
  input wire logic go, // Start.
  input wire logic slow, // Gap between bytes.
  input wire logic [111:0] frame, // First byte on top.
  input wire logic [3:0] count, // Bytes.
  output logic cmdValid, // Strobe.
  output logic [7:0] cmdByte, // Byte.
  output logic sending // Busy.
);
  logic [3:0] idx = 4'h0;
  logic gap = 1'b0;
  initial {cmdValid, cmdByte, sending} = 10'h000;
  // Off the strobe the byte lines invert every cycle, starting from the last byte.
  always @(posedge clk) begin
    cmdValid <= 1'b0;
    cmdByte <= ~cmdByte;
    gap <= 1'b0;
    if (go && !sending) begin
      sending <= 1'b1;
      idx <= 4'h0;
    end else if (sending && slow && !gap) begin
      gap <= 1'b1;
    end else if (sending) begin
      cmdValid <= 1'b1;
      cmdByte <= frame[8*(13-idx)+:8];
      idx <= idx + 4'h1;
      sending <= idx + 4'h1 != count;
    end
  end
endmodule : eis_terminal_model

/* sim/testbench.sv */
// Self-checking bench for the identifier store command handler.
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0, resetn = 1'b0, go = 1'b0, slow = 1'b0, usage = 1'b0;
  logic sec = 1'b0, respValid, fileWrite, cmdValid;
  logic [7:0] cmdByte, respByte;
  logic [15:0] statusWord;
  logic [55:0] fileData, id, shadow = 56'h0;
  logic [111:0] frame = 112'h0;
  logic [3:0] count = 4'h0;
  logic [79:0] e, m;
  logic [79:0] expQ[$];
  logic [71:0] bad [7] = '{72'h80_DE00_0008_0107_6E00,
    72'hA0_DF00_0008_0107_6D00, 72'hA0_DE02_0008_0107_6B00,
    72'hA0_DE00_0108_0107_6B00, 72'hA0_DE00_0007_0107_6700,
    72'hA0_DE01_0008_0207_6700, 72'hA0_DE00_0008_0108_6700};
  integer seed = 42277, failures = 0, checks = 0, k;
  always #50 clk = ~clk;
  eis_terminal_model partner (.clk(clk), .go(go), .slow(slow),
    .frame(frame), .count(count), .cmdValid(cmdValid), .cmdByte(cmdByte),
    .sending());
  eis_store_cmd dut (.clk(clk), .resetn(resetn), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .usageIndicator(usage), .secureIdUsed(sec),
    .respValid(respValid), .respByte(respByte), .statusWord(statusWord),
    .fileWrite(fileWrite), .fileData(fileData), .busy());
  task check(input string what, input logic [55:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task send(input logic [55:0] h, input logic sl, u, s, input logic [15:0] sw);
    logic [111:0] f;
    integer n;
    f = {h, 56'h0};
    for (n = 0; n < 7; n++) f[8*(6-n)+:8] = id[8*n+:8];
    e = {sw, 8'h00, shadow};
    // Bit 5 is expected only for selector 01.
    if (sw == 16'h9000) e = {sw, 2'h0, s & h[32], u, 3'h0, id != shadow, id};
    if (sw == 16'h9000) shadow = id;
    expQ.push_back(e);
    @(posedge clk);
    {frame, slow, usage, sec, go} <= {f, sl, u, s, 1'b1};
    count <= (h[23:16] == 8'h08) ? 4'hE : 4'h6;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 60 && respValid !== 1'b1; n++) @(negedge clk);
    if (n == 60) failures++;
    if (n == 60) close_out;
    $display("test done status %h", sw);
  endtask : send
  always @(negedge clk) begin
    if (respValid === 1'b1 && expQ.size() == 0) check("queue", 56'h1, 56'h0);
    if (respValid === 1'b1 && expQ.size() > 0) begin
      m = expQ.pop_front();
      check("reply", 56'({statusWord, respByte}), 56'(m[79:56]));
      check("file", fileData, m[55:0]);
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    id = 56'({$random(seed), $random(seed)});
    send(56'hA0_DE00_0008_0107, 1'b0, 1'b1, 1'b1, 16'h9000);
    send(56'hA0_DE00_0008_0107, 1'b0, 1'b0, 1'b1, 16'h9000);
    id = 56'({$random(seed), $random(seed)});
    send(56'hA0_DE01_0008_0107, 1'b1, 1'b0, 1'b1, 16'h9000);
    send(56'hA0_DE01_0008_0107, 1'b0, 1'b1, 1'b0, 16'h9000);
    for (k = 0; k < 7; k++) begin
      id = 56'({$random(seed), $random(seed)});
      send(bad[k][71:16], k[0], 1'b1, 1'b1, bad[k][15:0]);
    end
    close_out;
  end
endmodule : testbench
